// ===== urb_top.sv
// receive buffer and status logic of a serial receiver
// assumes an upstream bit sampler delivering whole frames as one-cycle pulses
// on clock_in, and a plain register port with read data one cycle later
`timescale 1ns/100ps
`include "urb_cfg.svh"
// Functional notes
// - receive-complete flag shows buffer not empty
// - receiver disable flushes buffer at once
// - interrupt requested while flag set and enabled
// - data read pops one buffer entry
// - error bits stored with each entry
// - error flag writes are ignored
// - error flags never raise interrupts
// - frame error is first stop bit low
// - frame error ignores stop-bit count
// - overrun: full, waiting frame, new start
// - overrun clears on successful transfer
// - parity checked only when enable bit set
// - parity mismatch stored in buffer entry
// - parity error zero unless checking enabled
// - disable abandons frame in progress
// - disabled receiver releases serial pin
// - ninth bit stored, read from control
// - unused upper data bits read zero
module urb_top
   import urb_pkg::*;
(
   input  wire logic          clock_in,
   input  wire logic          sys_rst_in,
   input  urb_pkg::urb_addr_t reg_addr_in,
   input  urb_pkg::urb_byte_t reg_wdata_in,
   input  wire logic          reg_write_in,
   input  wire logic          reg_read_in,
   output urb_pkg::urb_byte_t reg_rdata_out,
   input  wire logic          global_irq_enable_in,
   input  wire logic          frame_start_in,
   input  wire logic          frame_done_in,
   input  wire logic [8:0]    frame_data_in,
   input  wire logic          frame_parity_in,
   input  wire logic          frame_stop_in,
   output logic               receiver_active_out,
   output logic               pin_override_out,
   output logic               rx_irq_out
);
   logic       receiver_enable;
   logic       receive_complete_irq_enable;
   urb_byte_t  serial_format_reg;
   urb_byte_t  rdata;
   // shift register holding a finished frame until the buffer has room
   urb_entry_t shift_entry;
   logic       shift_full;
   logic       overrun_pend;
   logic       mismatch;
   logic       fifo_empty;
   logic       fifo_full;
   logic       pop;
   logic       push;
   logic       flush;
   urb_entry_t head;
   urb_entry_t next_entry;
   logic [2:0] size_code;
   logic [8:0] masked;
   logic       control_size2;

   function automatic logic sel(input urb_addr_t a, input urb_addr_t target);
      sel = (a == target);
   endfunction

   assign size_code = {control_size2, serial_format_reg[`URB_FM_SIZE_HI:`URB_FM_SIZE_LO]};

   // mask data bits above the configured character size
   always_comb
   begin
      masked = {1'b0, frame_data_in[7:0]};
      unique case (size_code[1:0])
         2'b00: masked = {4'h0, frame_data_in[4:0]};
         2'b01: masked = {3'h0, frame_data_in[5:0]};
         2'b10: masked = {2'h0, frame_data_in[6:0]};
         2'b11:
            if (size_code == `URB_SIZE9_CODE)
               masked = frame_data_in;
      endcase
   end

   urb_parity u_parity (
      .data_in       (masked),
      .parity_bit_in (frame_parity_in),
      .odd_in        (serial_format_reg[`URB_FM_UPM0]),
      .mismatch_out  (mismatch)
   );

   always_comb
   begin
      next_entry.bit8 = masked[8];
      next_entry.data = masked[7:0];
      next_entry.fe   = ~frame_stop_in;
      next_entry.dor  = 1'b0;
      next_entry.upe  = serial_format_reg[`URB_FM_UPM1] & mismatch;
   end

   assign flush = ~receiver_enable;
   assign pop   = reg_read_in && sel(reg_addr_in, `URB_ADDR_DATA) && !fifo_empty;
   assign push  = shift_full && (!fifo_full || pop);

   urb_fifo u_fifo (
      .clock_in     (clock_in),
      .sys_rst_in   (sys_rst_in),
      .flush_in     (flush),
      .push_in      (push),
      .push_data_in ({shift_entry.bit8, shift_entry.data, shift_entry.fe,
                      overrun_pend, shift_entry.upe}),
      .pop_in       (pop),
      .head_out     (head),
      .empty_out    (fifo_empty),
      .full_out     (fifo_full)
   );

   always_ff @(posedge clock_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         shift_full  <= 1'b0;
         shift_entry <= '0;
      end
      else if (flush)
         shift_full <= 1'b0;
      else if (frame_done_in && (!shift_full || push))
      begin
         shift_full  <= 1'b1;
         shift_entry <= next_entry;
      end
      else if (push)
         shift_full <= 1'b0;
   end

   // overrun is carried by the next frame that reaches the buffer
   always_ff @(posedge clock_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
         overrun_pend <= 1'b0;
      else if (flush)
         overrun_pend <= 1'b0;
      // lost frame marks overrun; set wins
      else if (frame_start_in && fifo_full && shift_full && !pop)
         overrun_pend <= 1'b1;
      else if (push)
         overrun_pend <= 1'b0;
   end

   always_ff @(posedge clock_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         receiver_enable             <= 1'(`URB_CONTROL_RST >> `URB_CT_RXEN);
         receive_complete_irq_enable <= 1'b0;
         control_size2               <= 1'b0;
         serial_format_reg           <= `URB_FORMAT_RST;
      end
      else if (reg_write_in)
      begin
         if (sel(reg_addr_in, `URB_ADDR_CONTROL))
         begin
            receiver_enable             <= reg_wdata_in[`URB_CT_RXEN];
            receive_complete_irq_enable <= reg_wdata_in[`URB_CT_RXCIE];
            control_size2               <= reg_wdata_in[`URB_CT_SIZE2];
         end
         if (sel(reg_addr_in, `URB_ADDR_FORMAT))
            serial_format_reg <= reg_wdata_in;
      end
   end

   always_comb
   begin
      rdata = 8'h00;
      unique case (reg_addr_in)
         `URB_ADDR_STATUS:
         begin
            rdata[`URB_ST_RXC] = !fifo_empty;
            rdata[`URB_ST_FE]  = !fifo_empty & head.fe;
            rdata[`URB_ST_DOR] = !fifo_empty & head.dor;
            rdata[`URB_ST_UPE] = !fifo_empty & head.upe;
         end
         `URB_ADDR_CONTROL:
         begin
            rdata[`URB_CT_RXCIE] = receive_complete_irq_enable;
            rdata[`URB_CT_RXEN]  = receiver_enable;
            rdata[`URB_CT_SIZE2] = control_size2;
            rdata[`URB_CT_RXB8]  = !fifo_empty & head.bit8;
         end
         `URB_ADDR_FORMAT: rdata = serial_format_reg;
         `URB_ADDR_DATA: rdata = fifo_empty ? 8'h00 : head.data;
         default: rdata = 8'h00;
      endcase
   end

   always_ff @(posedge clock_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
         reg_rdata_out <= 8'h00;
      else if (reg_read_in)
         reg_rdata_out <= rdata;
      else
         reg_rdata_out <= 8'h00;
   end

   assign rx_irq_out = receive_complete_irq_enable & global_irq_enable_in & !fifo_empty;
   assign pin_override_out    = receiver_enable;
   assign receiver_active_out = receiver_enable;

   logic unused_size;
   assign unused_size = ^size_code ^ serial_format_reg[`URB_FM_USBS];

   property p_flush_empties;
      @(posedge clock_in) disable iff (sys_rst_in)
      !receiver_enable |=> fifo_empty && !shift_full;
   endproperty
   a_flush_empties: assert property (p_flush_empties)
      else $error("buffer not flushed on disable");

   property p_irq_level;
      @(posedge clock_in) disable iff (sys_rst_in)
      (reg_read_in && reg_addr_in == `URB_ADDR_STATUS && receive_complete_irq_enable
         && global_irq_enable_in) |=> reg_rdata_out[`URB_ST_RXC] == $past(rx_irq_out);
   endproperty
   a_irq_level: assert property (p_irq_level)
      else $error("irq does not follow flag");

   property p_pop_one;
      @(posedge clock_in) disable iff (sys_rst_in)
      (pop && fifo_full && !push && receiver_enable) |=> !fifo_full && !fifo_empty;
   endproperty
   a_pop_one: assert property (p_pop_one)
      else $error("read did not pop one entry");

   property p_no_par_when_off;
      @(posedge clock_in) disable iff (sys_rst_in)
      (frame_done_in && !serial_format_reg[`URB_FM_UPM1] && !shift_full && receiver_enable)
         |=> !shift_entry.upe;
   endproperty
   a_no_par_when_off: assert property (p_no_par_when_off)
      else $error("parity error with checking off");

   property p_fe_stop;
      @(posedge clock_in) disable iff (sys_rst_in)
      (frame_done_in && !shift_full && receiver_enable) |=> shift_entry.fe == !$past(frame_stop_in);
   endproperty
   a_fe_stop: assert property (p_fe_stop)
      else $error("frame error mismatch");

   property p_overrun_set;
      @(posedge clock_in) disable iff (sys_rst_in)
      (frame_start_in && fifo_full && shift_full && !pop && receiver_enable) |=> overrun_pend;
   endproperty
   a_overrun_set: assert property (p_overrun_set)
      else $error("overrun not flagged");

   property p_overrun_clear;
      @(posedge clock_in) disable iff (sys_rst_in)
      (push && !frame_start_in && receiver_enable) |=> !overrun_pend;
   endproperty
   a_overrun_clear: assert property (p_overrun_clear)
      else $error("overrun not cleared on transfer");

   property p_hold_full;
      @(posedge clock_in) disable iff (sys_rst_in)
      (shift_full && fifo_full && !pop && receiver_enable) |=> shift_full;
   endproperty
   a_hold_full: assert property (p_hold_full)
      else $error("held frame dropped");

   property p_pin_release;
      @(posedge clock_in) disable iff (sys_rst_in)
      (reg_write_in && reg_addr_in == `URB_ADDR_CONTROL)
         |=> pin_override_out == $past(reg_wdata_in[`URB_CT_RXEN]);
   endproperty
   a_pin_release: assert property (p_pin_release)
      else $error("pin not released");

   property p_rxc_flag;
      @(posedge clock_in) disable iff (sys_rst_in)
      (reg_read_in && reg_addr_in == `URB_ADDR_STATUS)
         |=> reg_rdata_out[`URB_ST_RXC] != $past(fifo_empty);
   endproperty
   a_rxc_flag: assert property (p_rxc_flag)
      else $error("receive-complete flag wrong");

   property p_irq_empty;
      @(posedge clock_in) disable iff (sys_rst_in)
      fifo_empty |-> !rx_irq_out;
   endproperty
   a_irq_empty: assert property (p_irq_empty)
      else $error("irq raised with empty buffer");

   property p_pop_last;
      @(posedge clock_in) disable iff (sys_rst_in)
      (pop && !push && !fifo_full && receiver_enable) |=> fifo_empty;
   endproperty
   a_pop_last: assert property (p_pop_last)
      else $error("last entry not popped");

   property p_par_stored;
      @(posedge clock_in) disable iff (sys_rst_in)
      (frame_done_in && !shift_full && receiver_enable && serial_format_reg[`URB_FM_UPM1])
         |=> shift_entry.upe
             == $past(^masked ^ frame_parity_in ^ serial_format_reg[`URB_FM_UPM0]);
   endproperty
   a_par_stored: assert property (p_par_stored)
      else $error("parity result not stored");

   property p_upper_zero;
      @(posedge clock_in) disable iff (sys_rst_in)
      (frame_done_in && !shift_full && receiver_enable && size_code == 3'h0)
         |=> shift_entry.data[7:5] == 3'h0;
   endproperty
   a_upper_zero: assert property (p_upper_zero)
      else $error("unused data bits not zero");

   property p_ninth_bit;
      @(posedge clock_in) disable iff (sys_rst_in)
      (frame_done_in && !shift_full && receiver_enable)
         |=> shift_entry.bit8 == ($past(frame_data_in[8]) && $past(size_code) == `URB_SIZE9_CODE);
   endproperty
   a_ninth_bit: assert property (p_ninth_bit)
      else $error("ninth bit stored wrongly");

   property p_flush_overrun;
      @(posedge clock_in) disable iff (sys_rst_in)
      !receiver_enable |=> !overrun_pend;
   endproperty
   a_flush_overrun: assert property (p_flush_overrun)
      else $error("overrun kept while disabled");
endmodule // urb_top

// ===== urb_cfg.svh
// register offsets, field positions, reset values and sizes of the receive buffer block
// assumes a plain one-cycle register port with read data one cycle later
`ifndef URB_CFG_SVH
`define URB_CFG_SVH
`define URB_ADDR_STATUS   3'h0
`define URB_ADDR_CONTROL  3'h1
`define URB_ADDR_FORMAT   3'h2
`define URB_ADDR_DATA     3'h3
`define URB_ST_RXC        7
`define URB_ST_FE         4
`define URB_ST_DOR        3
`define URB_ST_UPE        2
`define URB_CT_RXCIE      7
`define URB_CT_RXEN       4
`define URB_CT_SIZE2      2
`define URB_CT_RXB8       1
`define URB_FM_UPM1       5
`define URB_FM_UPM0       4
`define URB_FM_USBS       3
`define URB_FM_SIZE_HI    2
`define URB_FM_SIZE_LO    1
`define URB_CONTROL_RST   8'h00
`define URB_FORMAT_RST    8'h06
`define URB_SIZE9_CODE    3'h7
`define URB_DEPTH         2
`endif

// ===== urb_pkg.sv
// types shared by the receive buffer block
// assumes urb_cfg.svh is on the include path
package urb_pkg;
   typedef logic [2:0] urb_addr_t;
   typedef logic [7:0] urb_byte_t;
   // one buffer entry: ninth bit, data, frame, overrun, parity error
   typedef struct packed {
      logic       bit8;
      logic [7:0] data;
      logic       fe;
      logic       dor;
      logic       upe;
   } urb_entry_t;
endpackage

// ===== urb_parity.sv
// parity check over a received character of five to nine bits
// assumes data bits above the character size are already zero
`timescale 1ns/100ps
module urb_parity
   import urb_pkg::*;
(
   input  wire logic [8:0] data_in,
   input  wire logic       parity_bit_in,
   input  wire logic       odd_in,
   output logic            mismatch_out
);
   // zero upper bits do not change xor parity, so size needs no mask here
   assign mismatch_out = (^data_in) ^ parity_bit_in ^ odd_in;
endmodule // urb_parity

// ===== urb_fifo.sv
// two-entry receive buffer in flip-flops with flush
// assumes push only when not full or together with a pop, and pop only when not empty
`timescale 1ns/100ps
`include "urb_cfg.svh"
module urb_fifo
   import urb_pkg::*;
(
   input  wire logic       clock_in,
   input  wire logic       sys_rst_in,
   input  wire logic       flush_in,
   input  wire logic       push_in,
   input  urb_pkg::urb_entry_t push_data_in,
   input  wire logic       pop_in,
   output urb_pkg::urb_entry_t head_out,
   output logic            empty_out,
   output logic            full_out
);
   urb_entry_t mem [`URB_DEPTH];
   logic       wr_ptr;
   logic       rd_ptr;
   logic [1:0] count;

   always_ff @(posedge clock_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count  <= 2'h0;
      end
      else if (flush_in)
      begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count  <= 2'h0;
      end
      else
      begin
         if (push_in)
            wr_ptr <= ~wr_ptr;
         if (pop_in)
            rd_ptr <= ~rd_ptr;
         if (push_in && !pop_in)
            count <= count + 2'h1;
         else if (pop_in && !push_in)
            count <= count - 2'h1;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < `URB_DEPTH; gi++)
      begin : g_entry
         always_ff @(posedge clock_in or posedge sys_rst_in)
         begin
            if (sys_rst_in)
               mem[gi] <= '0;
            else if (push_in && (wr_ptr == 1'(gi)))
               mem[gi] <= push_data_in;
         end
      end
   endgenerate

   assign head_out  = mem[rd_ptr];
   assign empty_out = (count == 2'h0);
   assign full_out  = (count == 2'h2);
endmodule // urb_fifo

// ===== urb_tx_model.sv
// remote serial transmitter model handing whole frames to the buffer block
// assumes calls start just after a rising edge of clock_in
`timescale 1ns/100ps
module urb_tx_model
(
   input  wire logic  clock_in,
   output logic       frame_start_out,
   output logic       frame_done_out,
   output logic [8:0] frame_data_out,
   output logic       frame_parity_out,
   output logic       frame_stop_out
);
   initial
   begin
      frame_start_out  = 1'b0;
      frame_done_out   = 1'b0;
      frame_data_out   = 9'h000;
      frame_parity_out = 1'b0;
      frame_stop_out   = 1'b1;
   end

   // gap sets a prompt or slow frame; released lines show the inverse, never stale
   task automatic send(input logic [8:0] d, input logic p, input logic s,
                       input bit st, input bit dn, input int gap);
      if (st)
      begin
         frame_start_out <= 1'b1;
         @(posedge clock_in);
         frame_start_out <= 1'b0;
         repeat (gap) @(posedge clock_in);
      end
      if (dn)
      begin
         frame_data_out   <= d;
         frame_parity_out <= p;
         frame_stop_out   <= s;
         frame_done_out   <= 1'b1;
         @(posedge clock_in);
         frame_done_out   <= 1'b0;
         frame_data_out   <= ~d;
         frame_parity_out <= ~p;
         frame_stop_out   <= ~s;
      end
   endtask
endmodule // urb_tx_model

// ===== urb_top_tb.sv
// self-checking bench for the receive buffer and status block
// assumes urb_cfg.svh on the include path and the transmitter model beside it
`timescale 1ns/100ps
`include "urb_cfg.svh"
module urb_top_tb;
   import urb_pkg::*;
   typedef struct {
      urb_byte_t  fmt;
      logic [8:0] d;
      logic       p;
      logic       s;
      urb_byte_t  st;
      urb_byte_t  q;
   } urb_row_t;
   logic       clock_in;
   logic       sys_rst_in;
   urb_addr_t  reg_addr_in;
   urb_byte_t  reg_wdata_in;
   logic       reg_write_in;
   logic       reg_read_in;
   urb_byte_t  reg_rdata_out;
   logic       global_irq_enable_in;
   logic       frame_start_in;
   logic       frame_done_in;
   logic [8:0] frame_data_in;
   logic       frame_parity_in;
   logic       frame_stop_in;
   logic       receiver_active_out;
   logic       pin_override_out;
   logic       rx_irq_out;
   int         bad_count;
   int         compares;
   int         n;
   urb_byte_t  v;
   urb_row_t   rows [10];

   urb_top DUT (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
      .reg_rdata_out(reg_rdata_out), .global_irq_enable_in(global_irq_enable_in),
      .frame_start_in(frame_start_in), .frame_done_in(frame_done_in),
      .frame_data_in(frame_data_in), .frame_parity_in(frame_parity_in),
      .frame_stop_in(frame_stop_in), .receiver_active_out(receiver_active_out),
      .pin_override_out(pin_override_out), .rx_irq_out(rx_irq_out));

   urb_tx_model tx (.clock_in(clock_in), .frame_start_out(frame_start_in),
      .frame_done_out(frame_done_in), .frame_data_out(frame_data_in),
      .frame_parity_out(frame_parity_in), .frame_stop_out(frame_stop_in));

   task automatic chk(input urb_byte_t seen, input urb_byte_t exp);
      compares++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr(input urb_addr_t a, input urb_byte_t d);
      @(posedge clock_in);
      reg_addr_in  <= a;
      reg_wdata_in <= d;
      reg_write_in <= 1'b1;
      @(posedge clock_in);
      reg_write_in <= 1'b0;
   endtask

   // read data stands only in the cycle after the strobe
   task automatic rd(input urb_addr_t a, output urb_byte_t d);
      @(posedge clock_in);
      reg_addr_in <= a;
      reg_read_in <= 1'b1;
      @(posedge clock_in);
      reg_read_in <= 1'b0;
      #1 d = reg_rdata_out;
   endtask

   task automatic results();
      $display("comparisons %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial
   begin
      clock_in = 1'b0;
      forever #20 clock_in = ~clock_in;
   end

   initial
   begin
      #4000000;
      bad_count++;
      results();
   end

   initial
   begin
      rows[0] = '{8'h06, 9'h0a5, 1'b0, 1'b1, 8'h80, 8'ha5};
      rows[1] = '{8'h06, 9'h0a5, 1'b0, 1'b0, 8'h90, 8'ha5};
      rows[2] = '{8'h26, 9'h003, 1'b0, 1'b1, 8'h80, 8'h03};
      rows[3] = '{8'h26, 9'h003, 1'b1, 1'b1, 8'h84, 8'h03};
      rows[4] = '{8'h36, 9'h003, 1'b0, 1'b1, 8'h84, 8'h03};
      rows[5] = '{8'h06, 9'h003, 1'b1, 1'b1, 8'h80, 8'h03};
      rows[6] = '{8'h00, 9'h0ff, 1'b0, 1'b1, 8'h80, 8'h1f};
      rows[7] = '{8'h0e, 9'h0a5, 1'b0, 1'b0, 8'h90, 8'ha5};
      rows[8] = '{8'h02, 9'h0ff, 1'b0, 1'b1, 8'h80, 8'h3f};
      rows[9] = '{8'h04, 9'h1ff, 1'b0, 1'b1, 8'h80, 8'h7f};
      bad_count = 0;
      compares = 0;
      sys_rst_in = 1'b1;
      reg_addr_in = 3'h0;
      reg_wdata_in = 8'h00;
      reg_write_in = 1'b0;
      reg_read_in = 1'b0;
      global_irq_enable_in = 1'b0;
      repeat (12) @(posedge clock_in);
      sys_rst_in <= 1'b0;
      #1 chk({5'h00, rx_irq_out, receiver_active_out, pin_override_out}, 8'h00);
      rd(`URB_ADDR_FORMAT, v); chk(v, `URB_FORMAT_RST);
      rd(`URB_ADDR_CONTROL, v); chk(v, `URB_CONTROL_RST);
      tx.send(9'h055, 1'b0, 1'b1, 1, 1, 2);
      rd(`URB_ADDR_STATUS, v); chk(v, 8'h00);
      wr(`URB_ADDR_CONTROL, 8'h10);
      #1 chk({6'h00, receiver_active_out, pin_override_out}, 8'h03);
      $display("test reset done");
      foreach (rows[i])
      begin
         wr(`URB_ADDR_FORMAT, rows[i].fmt);
         tx.send(rows[i].d, rows[i].p, rows[i].s, 1, 1, i);
         rd(`URB_ADDR_STATUS, v); chk(v, rows[i].st);
         rd(`URB_ADDR_DATA, v); chk(v, rows[i].q);
         rd(`URB_ADDR_STATUS, v); chk(v, 8'h00);
      end
      $display("test rows done");
      wr(`URB_ADDR_FORMAT, 8'h06);
      wr(`URB_ADDR_CONTROL, 8'h14);
      tx.send(9'h1c3, 1'b0, 1'b1, 1, 1, 1);
      rd(`URB_ADDR_CONTROL, v); chk(v, 8'h16);
      rd(`URB_ADDR_DATA, v); chk(v, 8'hc3);
      tx.send(9'h0a5, 1'b0, 1'b0, 1, 1, 1);
      wr(`URB_ADDR_STATUS, 8'h0c);
      rd(`URB_ADDR_STATUS, v); chk(v, 8'h90);
      wr(`URB_ADDR_STATUS, 8'h00);
      rd(`URB_ADDR_STATUS, v); chk(v, 8'h90);
      rd(`URB_ADDR_DATA, v); chk(v, 8'ha5);
      $display("test ninth bit and flag writes done");
      wr(`URB_ADDR_CONTROL, 8'h90);
      global_irq_enable_in <= 1'b1;
      tx.send(9'h011, 1'b0, 1'b0, 1, 1, 1);
      // frame reaches the buffer one cycle after the shifter
      @(posedge clock_in);
      #1 chk({7'h00, rx_irq_out}, 8'h01);
      @(posedge clock_in);
      global_irq_enable_in <= 1'b0;
      #1 chk({7'h00, rx_irq_out}, 8'h00);
      global_irq_enable_in <= 1'b1;
      rd(`URB_ADDR_DATA, v); chk({7'h00, rx_irq_out}, 8'h00);
      $display("test interrupt done");
      wr(`URB_ADDR_CONTROL, 8'h10);
      for (n = 0; n < 3; n++) tx.send(9'h0a0 + 9'(n), 1'b0, 1'b1, 1, 1, 0);
      // third frame waits in the shifter; a new start overruns
      tx.send(9'h0dd, 1'b0, 1'b1, 1, 0, 1);
      tx.send(9'h0dd, 1'b0, 1'b1, 0, 1, 0);
      for (n = 0; n < 3; n++)
      begin
         rd(`URB_ADDR_STATUS, v); chk(v, (n == 2) ? 8'h88 : 8'h80);
         rd(`URB_ADDR_DATA, v); chk(v, 8'ha0 + 8'(n));
      end
      rd(`URB_ADDR_STATUS, v); chk(v, 8'h00);
      tx.send(9'h0e1, 1'b0, 1'b1, 1, 1, 1);
      rd(`URB_ADDR_STATUS, v); chk(v, 8'h80);
      rd(`URB_ADDR_DATA, v); chk(v, 8'he1);
      $display("test overrun done");
      tx.send(9'h001, 1'b0, 1'b1, 1, 1, 0);
      tx.send(9'h002, 1'b0, 1'b1, 1, 1, 0);
      wr(`URB_ADDR_CONTROL, 8'h00);
      #1 chk({6'h00, receiver_active_out, pin_override_out}, 8'h00);
      wr(`URB_ADDR_CONTROL, 8'h10);
      rd(`URB_ADDR_STATUS, v); chk(v, 8'h00);
      tx.send(9'h0bb, 1'b0, 1'b1, 1, 0, 1);
      wr(`URB_ADDR_CONTROL, 8'h00);
      tx.send(9'h0bb, 1'b0, 1'b1, 0, 1, 0);
      wr(`URB_ADDR_CONTROL, 8'h10);
      rd(`URB_ADDR_STATUS, v); chk(v, 8'h00);
      $display("test disable done");
      tx.send(9'h031, 1'b0, 1'b1, 1, 1, 0);
      tx.send(9'h032, 1'b0, 1'b1, 1, 1, 5);
      n = 0;
      // software drain: status first, then data, bounded
      repeat (4)
      begin
         rd(`URB_ADDR_STATUS, v);
         if (v[`URB_ST_RXC] === 1'b1)
         begin
            rd(`URB_ADDR_DATA, v);
            n++;
         end
      end
      chk(8'(n), 8'h02);
      rd(`URB_ADDR_STATUS, v); chk(v, 8'h00);
      $display("test drain done");
      results();
   end
endmodule // urb_top_tb
